/* htx_map.svh */
`ifndef HTX_MAP_SVH
`define HTX_MAP_SVH
// How it works
// RULE1: Send one flag between messages when flag count select is 0, two when 1.
// RULE2: Loop bit set before last byte makes the message repeat until cleared or new data.
// RULE3: Clearing the loop bit finishes the current copy, then flags until new data.
// RULE4: New data during a loop ends it, sends one or two flags, then the new message.
// RULE5: Controller reset flushes the FIFO, then sends abort and fill until new data.
// RULE6: Controller reset bit is set by software and cleared by hardware when done.
// RULE7: Mapping select 0 uses a channel; 1 uses data link or Sa bits.
// RULE8: Fill between messages is the flag when fill select is 0, all ones when 1.
// RULE9: Software sets end of message just before writing the last byte.
// RULE10: Insert a zero after five ones in the message unless stuffing is defeated.
// RULE11: Append a two byte CRC to every message unless CRC is defeated.
// RULE12: Bit suppress bits keep those channel bit positions free of message data.
// RULE13: Rising abort bit flushes the FIFO, sends one abort byte, then fill.
// RULE14: Software clears and sets the abort bit again for another abort.
// RULE15: In T1 mode the send code bit sends the six-bit code register.
// RULE16: The controller runs only while its enable bit is 1.
// RULE17: A new carrier channel select is adopted only on a controller reset.
// RULE18: CRC is x16+x12+x5+1, preset ones, inverted, least significant bit first.

// ==========================================================
// Register indexes (byte address is four times the index)
`define HTX_IDX_CTL1 10'h110
`define HTX_IDX_SUPP 10'h111
`define HTX_IDX_FIFO 10'h112
`define HTX_IDX_CTL2 10'h113
`define HTX_IDX_STAT 10'h117
`define HTX_IDX_BOC 10'h163
`define HTX_REG_RST 8'h00

// ==========================================================
// Field positions
`define HTX_C1_FLAG_COUNT_SELECT 7
`define HTX_C1_LOOP 6
`define HTX_C1_RST 5
`define HTX_C1_MAP 4
`define HTX_C1_FS 3
`define HTX_C1_EOM 2
`define HTX_C1_ZSD 1
`define HTX_C1_CRCD 0
`define HTX_C2_ABT 7
`define HTX_C2_SEND_BIT_CODE 6
`define HTX_C2_EN 5

// ==========================================================
// Line codes, CRC and FIFO shape
`define HTX_FLAG 8'h7e
`define HTX_IDLE 8'hff
`define HTX_ABORT 8'hfe
`define HTX_BYTE_BITS 4'h8
`define HTX_STUFF_RUN 3'h5
`define HTX_CRC_PRESET 16'hffff
`define HTX_CRC_POLY 16'h8408
`define HTX_FIFO_DEPTH 7'h40
`define HTX_PTR_W 7
`define HTX_AW 6
`define HTX_MW 9

// ==========================================================
// Timing
`define HTX_CLK_NS 100
`define HTX_RST_LIMIT_NS 250000
`define HTX_RST_LIMIT_CYC (`HTX_RST_LIMIT_NS / `HTX_CLK_NS)
`define HTX_RST_CYC 4'h8
`endif

/* htx_pkg.sv */
`include "htx_map.svh"
package htx_pkg;
   typedef logic [`HTX_PTR_W-1:0] htx_ptr_t;

   typedef enum logic [2:0] {PH_FILL, PH_ABORT, PH_OPEN, PH_DATA, PH_CRC_LO, PH_CRC_HI,
      PH_CLOSE} htx_phase_t;

   typedef struct packed {
      logic [7:0] ctl1;
      logic [7:0] supp;
      logic [7:0] ctl2;
      logic [5:0] boc;
      logic [4:0] chan;
      logic [3:0] rst_cnt;
      htx_phase_t ph;
      logic flags_due;
      logic [7:0] sh;
      logic [3:0] bits_left;
      logic stuff_en;
      logic [2:0] ones;
      logic bit_out;
      logic boc_send;
      htx_ptr_t wr;
      htx_ptr_t rd;
      htx_ptr_t base;
      logic [7:0] prdata;
   } htx_state_t;

   typedef struct packed {
      logic [`HTX_FIFO_DEPTH-1:0][`HTX_MW-1:0] words;
      logic [`HTX_MW-1:0] rdata;
   } htx_mem_t;

   typedef struct packed {
      logic [15:0] crc;
   } htx_crc_t;
endpackage

/* htx_fifo_mem.sv */
`timescale 1ns/10ps
`include "htx_map.svh"
module htx_fifo_mem
   import htx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [`HTX_AW-1:0] wr_addr,
   input wire logic [`HTX_MW-1:0] wr_data,
   input wire logic [`HTX_AW-1:0] rd_addr,
   output logic [`HTX_MW-1:0] rd_data
);
   htx_mem_t mem_reg;
   htx_mem_t mem_next;

   always_comb
   begin
      mem_next = mem_reg;
      if (wr_en)
         mem_next.words[wr_addr] = wr_data;
      // Write-through so a byte is readable the cycle after it lands
      mem_next.rdata = (wr_en && wr_addr == rd_addr) ? wr_data : mem_reg.words[rd_addr];
   end

   // Storage itself is not reset; only the read register is
   always_ff @(posedge clk_sys)
   begin
      mem_reg <= mem_next;
      if (srst)
         mem_reg.rdata <= '0;
   end

   assign rd_data = mem_reg.rdata;
endmodule

/* htx_crc16.sv */
`timescale 1ns/10ps
`include "htx_map.svh"
module htx_crc16
   import htx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic start,
   input wire logic update,
   input wire logic [7:0] data_in,
   output logic [15:0] crc_out
);
   htx_crc_t crc_reg;
   htx_crc_t crc_next;
   logic [15:0] c;

   // Reflected form so the register matches LSB-first line order
   always_comb
   begin
      c = start ? `HTX_CRC_PRESET : crc_reg.crc; // see RULE18
      c = c ^ {8'h00, data_in};
      for (int i = 0; i < 8; i++)
         c = c[0] ? ((c >> 1) ^ `HTX_CRC_POLY) : (c >> 1);
      crc_next = crc_reg;
      if (update)
         crc_next.crc = c;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         crc_reg.crc <= `HTX_CRC_PRESET;
      else
         crc_reg <= crc_next;
   end

   assign crc_out = crc_reg.crc;
endmodule

/* htx_controller.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "htx_map.svh"
module htx_controller
   import htx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic t1_mode,
   input wire logic ch_slot,
   input wire logic [4:0] slot_chan,
   input wire logic [2:0] slot_bit,
   input wire logic dl_slot,
   output logic insert_enable,
   output logic tx_bit,
   output logic boc_send,
   output logic [5:0] boc_code
);
   htx_state_t state_reg;
   htx_state_t state_next;
   logic [9:0] idx;
   logic aligned;
   logic mapped;
   logic acc;
   logic wr_acc;
   logic fifo_full;
   logic fifo_avail;
   logic fifo_we;
   logic rst_busy;
   logic slot_ok;
   logic stuff_now;
   logic rst_start;
   logic abort_start;
   logic close_load;
   logic crc_start;
   logic crc_upd;
   logic take_data;
   logic first_byte;
   logic [7:0] rd_val;
   logic [`HTX_MW-1:0] mem_rdata;
   logic [15:0] crc_val;

   // ==========================================================
   // Bus decode
   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign mapped = aligned && (idx == `HTX_IDX_CTL1 || idx == `HTX_IDX_SUPP ||
      idx == `HTX_IDX_FIFO || idx == `HTX_IDX_CTL2 || idx == `HTX_IDX_STAT ||
      idx == `HTX_IDX_BOC);
   assign acc = psel && penable;
   assign wr_acc = acc && pwrite && mapped;
   assign pready = 1'b1;
   // A write into a full FIFO is dropped and flagged
   assign pslverr = acc && (!mapped || (pwrite && idx == `HTX_IDX_FIFO && fifo_full));
   assign prdata = {24'h000000, state_reg.prdata};

   assign fifo_full = (htx_ptr_t'(state_reg.wr - state_reg.base) == `HTX_FIFO_DEPTH);
   assign fifo_avail = (state_reg.wr != state_reg.rd);
   assign fifo_we = wr_acc && idx == `HTX_IDX_FIFO && !fifo_full;
   assign rst_busy = (state_reg.rst_cnt != 4'h0);
   assign rst_start = wr_acc && idx == `HTX_IDX_CTL1 && pwdata[`HTX_C1_RST];
   assign abort_start = wr_acc && idx == `HTX_IDX_CTL2 && pwdata[`HTX_C2_ABT] &&
      !state_reg.ctl2[`HTX_C2_ABT]; // see RULE13

   // ==========================================================
   // Line slot selection
   assign slot_ok = state_reg.ctl2[`HTX_C2_EN] && !rst_busy && // see RULE16
      (state_reg.ctl1[`HTX_C1_MAP] ? dl_slot : // see RULE7
      (ch_slot && slot_chan == state_reg.chan && !state_reg.supp[slot_bit])); // see RULE12
   assign insert_enable = slot_ok;
   assign tx_bit = state_reg.bit_out;
   assign boc_send = state_reg.boc_send;
   assign boc_code = state_reg.boc;
   // Ones only count on stuffable bits, so a run ending a CRC still gets its zero before the flag
   assign stuff_now = state_reg.ones == `HTX_STUFF_RUN;

   always_comb
   begin
      case (idx)
         `HTX_IDX_CTL1: rd_val = state_reg.ctl1 | {2'b00, rst_busy, 5'b00000};
         `HTX_IDX_SUPP: rd_val = state_reg.supp;
         `HTX_IDX_CTL2: rd_val = state_reg.ctl2;
         `HTX_IDX_BOC: rd_val = {2'b00, state_reg.boc};
         `HTX_IDX_STAT: rd_val = {5'b00000, (state_reg.ph == PH_DATA), fifo_full, !fifo_avail};
         default: rd_val = 8'h00;
      endcase
   end

   htx_fifo_mem u_mem (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_en(fifo_we),
      .wr_addr(state_reg.wr[`HTX_AW-1:0]),
      .wr_data({state_reg.ctl1[`HTX_C1_EOM] | state_reg.ctl1[`HTX_C1_LOOP], pwdata[7:0]}),
      .rd_addr(state_reg.rd[`HTX_AW-1:0]),
      .rd_data(mem_rdata)
   );

   htx_crc16 u_crc (
      .clk_sys(clk_sys),
      .srst(srst),
      .start(crc_start),
      .update(crc_upd),
      .data_in(mem_rdata[7:0]),
      .crc_out(crc_val)
   );

   // ==========================================================
   // Register file, bit engine and framing
   always_comb
   begin
      state_next = state_reg;
      close_load = 1'b0;
      take_data = 1'b0;
      first_byte = 1'b0;
      crc_start = 1'b0;
      crc_upd = 1'b0;
      if (rst_busy)
         state_next.rst_cnt = state_reg.rst_cnt - 4'h1; // see RULE6
      if (wr_acc)
      begin
         case (idx)
            `HTX_IDX_CTL1:
            begin
               state_next.ctl1 = pwdata[7:0];
               state_next.ctl1[`HTX_C1_RST] = 1'b0;
            end
            `HTX_IDX_SUPP: state_next.supp = pwdata[7:0];
            `HTX_IDX_CTL2: state_next.ctl2 = pwdata[7:0];
            `HTX_IDX_BOC: state_next.boc = pwdata[5:0];
            `HTX_IDX_FIFO:
            begin
               if (!fifo_full)
                  state_next.wr = state_reg.wr + 7'h01;
            end
            default: state_next.boc = state_reg.boc;
         endcase
      end
      // A fresh reset write restarts the countdown, so set wins
      if (rst_start)
         state_next.rst_cnt = `HTX_RST_CYC; // see RULE6
      if (setup_rd())
         state_next.prdata = rd_val;
      if (slot_ok)
      begin
         if (stuff_now)
            state_next.ones = 3'h0; // see RULE10
         else
         begin
            state_next.ones = (state_reg.sh[0] && state_reg.stuff_en) ?
               state_reg.ones + 3'h1 : 3'h0;
            state_next.sh = {1'b0, state_reg.sh[7:1]};
            state_next.bits_left = state_reg.bits_left - 4'h1;
         end
      end
      if (rst_start || abort_start)
      begin
         // Drop the byte in flight so the abort goes out at once
         state_next.ph = PH_ABORT; // see RULE5
         state_next.bits_left = 4'h0;
         state_next.ones = 3'h0;
         state_next.stuff_en = 1'b0;
         state_next.rd = rst_start ? 7'h00 : state_reg.wr;
         state_next.base = rst_start ? 7'h00 : state_reg.wr;
         if (rst_start)
         begin
            state_next.wr = 7'h00;
            state_next.chan = state_reg.ctl2[4:0]; // see RULE17
         end
      end
      if (state_next.bits_left == 4'h0)
      begin
         state_next.bits_left = `HTX_BYTE_BITS;
         state_next.stuff_en = 1'b0;
         case (state_next.ph)
            PH_ABORT:
            begin
               state_next.sh = `HTX_ABORT; // see RULE13
               state_next.ph = PH_FILL;
            end
            PH_OPEN:
            begin
               if (state_reg.flags_due)
               begin
                  state_next.sh = `HTX_FLAG; // see RULE1
                  state_next.flags_due = 1'b0;
               end
               else if (fifo_avail)
               begin
                  take_data = 1'b1;
                  first_byte = 1'b1;
               end
               else
               begin
                  state_next.sh = state_reg.ctl1[`HTX_C1_FS] ? `HTX_IDLE : `HTX_FLAG;
                  state_next.ph = PH_FILL;
               end
            end
            PH_DATA:
            begin
               if (fifo_avail)
                  take_data = 1'b1;
               else
               begin
                  // Underrun mid-message: nothing valid can follow
                  state_next.sh = `HTX_ABORT;
                  state_next.ph = PH_FILL;
               end
            end
            PH_CRC_LO:
            begin
               state_next.sh = ~crc_val[7:0]; // see RULE18
               state_next.stuff_en = !state_reg.ctl1[`HTX_C1_ZSD];
               state_next.ph = PH_CRC_HI;
            end
            PH_CRC_HI:
            begin
               state_next.sh = ~crc_val[15:8]; // see RULE11
               state_next.stuff_en = !state_reg.ctl1[`HTX_C1_ZSD];
               state_next.ph = PH_CLOSE;
            end
            PH_CLOSE:
            begin
               close_load = 1'b1;
               state_next.sh = `HTX_FLAG;
               state_next.flags_due = state_reg.ctl1[`HTX_C1_FLAG_COUNT_SELECT]; // see RULE1
               state_next.ph = PH_OPEN;
               if (state_reg.ctl1[`HTX_C1_LOOP] && !fifo_avail)
                  state_next.rd = state_reg.base; // see RULE2
               else
                  state_next.base = state_reg.rd; // see RULE3 RULE4
            end
            default:
            begin
               state_next.ph = fifo_avail ? PH_OPEN : PH_FILL;
               state_next.flags_due = 1'b0;
               state_next.sh = (fifo_avail || !state_reg.ctl1[`HTX_C1_FS]) ?
                  `HTX_FLAG : `HTX_IDLE; // see RULE8
            end
         endcase
         if (take_data)
         begin
            state_next.sh = mem_rdata[7:0];
            state_next.stuff_en = !state_reg.ctl1[`HTX_C1_ZSD]; // see RULE10
            state_next.rd = state_reg.rd + 7'h01;
            crc_upd = 1'b1;
            crc_start = first_byte;
            // End of message flag closes it; CRC may be skipped
            state_next.ph = !mem_rdata[8] ? PH_DATA :
               state_reg.ctl1[`HTX_C1_CRCD] ? PH_CLOSE : PH_CRC_LO; // see RULE11
         end
      end
      state_next.bit_out = (state_next.ones == `HTX_STUFF_RUN) ? 1'b0 : state_next.sh[0]; // see RULE10
      state_next.boc_send = state_reg.ctl2[`HTX_C2_SEND_BIT_CODE] && t1_mode; // see RULE15
   end

   function automatic logic setup_rd();
      setup_rd = psel && !penable && !pwrite;
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   // ==========================================================
   // Checks
   localparam int RST_B = 8;
   logic [7:0] fs_mux;
   assign fs_mux = state_reg.ctl1[`HTX_C1_FS] ? `HTX_IDLE : `HTX_FLAG;

   property p_rst_done;
      @(posedge clk_sys) disable iff (srst)
      rst_start |=> rst_busy ##[1:RST_B] !rst_busy;
   endproperty
   a_rst_done: assert property (p_rst_done) else $error("reset bit did not clear"); // see RULE6

   property p_rst_flush;
      @(posedge clk_sys) disable iff (srst)
      rst_start |=> state_reg.wr == 7'h00 && state_reg.rd == 7'h00 && state_reg.ph == PH_FILL;
   endproperty
   a_rst_flush: assert property (p_rst_flush) else $error("reset did not flush"); // see RULE5

   property p_chan_hold;
      @(posedge clk_sys) disable iff (srst)
      !rst_start |=> $stable(state_reg.chan);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel changed"); // see RULE17

   property p_abort;
      @(posedge clk_sys) disable iff (srst)
      (abort_start && !rst_start) |=> state_reg.sh == `HTX_ABORT && state_reg.rd == $past(state_reg.wr);
   endproperty
   a_abort: assert property (p_abort) else $error("abort not sent"); // see RULE13

   property p_stuff;
      @(posedge clk_sys) disable iff (srst)
      (stuff_now && state_reg.bits_left != 4'h0) |-> tx_bit == 1'b0;
   endproperty
   a_stuff: assert property (p_stuff) else $error("zero not stuffed"); // see RULE10

   property p_disabled;
      @(posedge clk_sys) disable iff (srst)
      !state_reg.ctl2[`HTX_C2_EN] |-> !insert_enable;
   endproperty
   a_disabled: assert property (p_disabled) else $error("inserted while disabled"); // see RULE16

   property p_suppress;
      @(posedge clk_sys) disable iff (srst)
      (!state_reg.ctl1[`HTX_C1_MAP] && state_reg.supp[slot_bit]) |-> !insert_enable;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppressed bit used"); // see RULE12

   property p_boc;
      @(posedge clk_sys) disable iff (srst)
      boc_send |-> $past(t1_mode) && $past(state_reg.ctl2[`HTX_C2_SEND_BIT_CODE]);
   endproperty
   a_boc: assert property (p_boc) else $error("code sent outside T1"); // see RULE15

   property p_close_flags;
      @(posedge clk_sys) disable iff (srst)
      close_load |=> state_reg.sh == `HTX_FLAG && state_reg.flags_due == $past(state_reg.ctl1[7]);
   endproperty
   a_close_flags: assert property (p_close_flags) else $error("flag count wrong"); // see RULE1

   property p_loop;
      @(posedge clk_sys) disable iff (srst)
      (close_load && state_reg.ctl1[`HTX_C1_LOOP] && !fifo_avail) |=>
         state_reg.rd == $past(state_reg.base);
   endproperty
   a_loop: assert property (p_loop) else $error("loop did not rewind"); // see RULE2

   property p_fill;
      @(posedge clk_sys) disable iff (srst)
      (state_reg.ph == PH_FILL && state_next.bits_left == `HTX_BYTE_BITS && !fifo_avail &&
         state_reg.bits_left != `HTX_BYTE_BITS && !wr_acc) |=> state_reg.sh == $past(fs_mux);
   endproperty
   a_fill: assert property (p_fill) else $error("wrong fill byte"); // see RULE8

   property p_crc_lo;
      @(posedge clk_sys) disable iff (srst)
      (state_reg.ph == PH_CRC_LO && state_next.ph == PH_CRC_HI && !wr_acc) |=>
         state_reg.sh == ~$past(crc_val[7:0]);
   endproperty
   a_crc_lo: assert property (p_crc_lo) else $error("CRC byte wrong"); // see RULE11

   c_loop: cover property (@(posedge clk_sys) disable iff (srst)
      close_load && state_reg.ctl1[`HTX_C1_LOOP] && !fifo_avail);
   c_abort: cover property (@(posedge clk_sys) disable iff (srst) abort_start);
   c_crc: cover property (@(posedge clk_sys) disable iff (srst) state_reg.ph == PH_CRC_HI);
   c_stuff: cover property (@(posedge clk_sys) disable iff (srst) stuff_now && slot_ok);
endmodule

/* htx_far_end.sv */
`timescale 1ns/10ps
// ==========
// Far end: framer slot source and HDLC receiver
module htx_far_end
(
   input wire logic clk_sys,
   input wire logic use_ch,
   input wire logic insert_enable,
   input wire logic tx_bit,
   output logic ch_slot,
   output logic [4:0] slot_chan,
   output logic [2:0] slot_bit,
   output logic dl_slot,
   output logic rx_stb,
   output logic [7:0] rx_byte,
   output int flag_cnt,
   output int abort_cnt
);
   logic [4:0] cnt = 5'h00;
   logic bad = 1'b1;
   logic [7:0] v;
   int ones = 0;
   logic q[$];
   logic [7:0] oq[$];
   initial
   begin
      {ch_slot, dl_slot, rx_stb, slot_chan, slot_bit, rx_byte} = '0;
      flag_cnt = 0;
      abort_cnt = 0;
   end
   // Data link slots come at random so their take cadence is not fixed; channel slots follow cnt
   always @(posedge clk_sys)
   begin
      cnt <= cnt + 5'h01;
      ch_slot <= use_ch;
      dl_slot <= !use_ch && $urandom_range(1);
      slot_chan <= {3'h0, cnt[4:3]};
      slot_bit <= cnt[2:0];
      rx_stb <= oq.size() > 0;
      if (oq.size() > 0)
         rx_byte <= oq.pop_front();
      if (insert_enable === 1'b1)
      begin
         if (tx_bit)
         begin
            q.push_back(1'b1);
            ones++;
            // Seven ones mark an abort; the frame so far is thrown away
            if (ones == 7)
            begin
               abort_cnt <= abort_cnt + 1;
               bad = 1'b1;
            end
         end
         else if (ones == 6)
         begin
            flag_cnt <= flag_cnt + 1;
            if (!bad && q.size() > 7 && (q.size() - 7) % 8 == 0)
               for (int k = 0; k < (q.size() - 7) / 8; k++)
               begin
                  for (int i = 0; i < 8; i++)
                     v[i] = q[8 * k + i];
                  oq.push_back(v);
               end
            q.delete();
            bad = 1'b0;
            ones = 0;
         end
         else
         begin
            if (ones != 5)
               q.push_back(1'b0);
            ones = 0;
         end
      end
   end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
`include "htx_map.svh"
module testbench;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, t1_mode = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, insert_enable, tx_bit, boc_send, ch_slot, dl_slot, rx_stb;
   logic use_ch = 1'b0, en = 1'b0;
   logic [4:0] slot_chan, lch = 5'h00;
   logic [2:0] slot_bit;
   logic [5:0] boc_code;
   logic [7:0] rx_byte, r, c, sp = 8'h00;
   logic [8:0] x;
   logic [8:0] eq[$];
   logic [7:0] fq[$];
   int err_count = 0, n_checks = 0, flag_cnt, abort_cnt, f0;

   initial
      forever #50 clk_sys = ~clk_sys;

   htx_controller u_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .t1_mode(t1_mode), .ch_slot(ch_slot), .slot_chan(slot_chan),
      .slot_bit(slot_bit), .dl_slot(dl_slot), .insert_enable(insert_enable),
      .tx_bit(tx_bit), .boc_send(boc_send), .boc_code(boc_code));
   htx_far_end u_far (.clk_sys(clk_sys), .use_ch(use_ch), .insert_enable(insert_enable),
      .tx_bit(tx_bit), .ch_slot(ch_slot), .slot_chan(slot_chan), .slot_bit(slot_bit),
      .dl_slot(dl_slot), .rx_stb(rx_stb), .rx_byte(rx_byte), .flag_cnt(flag_cnt),
      .abort_cnt(abort_cnt));

   // ==========
   // Checking and closing
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("TB: checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk_sys)
      if (psel && penable && pready === 1'b1)
      begin
         x = eq.pop_front();
         chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, {x[8], 24'h0, x[7:0]});
      end

   always @(posedge clk_sys)
      if (rx_stb === 1'b1)
         chk("rx_byte", rx_byte, fq.size() > 0 ? {1'b0, fq.pop_front()} : 9'h100);

   // Every take must land on an offered slot: an unsuppressed bit of the latched channel, or a data link bit
   always @(posedge clk_sys)
      if (insert_enable === 1'b1)
         chk("take", en && (use_ch ? ch_slot && slot_chan == lch && !sp[slot_bit] : dl_slot),
            1'b1);

   // ==========
   // Bus and stream tasks
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
      input logic e = 1'b0);
      int n = 0;
      eq.push_back({e, w ? 8'h00 : d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1 && ++n < 50);
      if (n >= 50)
      begin
         err_count++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // First byte is all ones so that stuffing is always exercised
   task automatic send(input int n, input logic [7:0] c1, input logic [7:0] fin, input int cp);
      logic [15:0] s = 16'hffff;
      logic [7:0] v;
      logic [7:0] b[$];
      for (int k = 0; k < n; k++)
      begin
         v = k == 0 ? 8'hff : 8'($urandom);
         b.push_back(v);
         for (int i = 0; i < 8; i++)
            s = s[0] ^ v[i] ? (s >> 1) ^ 16'h8408 : s >> 1;
         if (k == n - 1)
            apb(1'b1, `HTX_IDX_CTL1, c1 | fin);
         apb(1'b1, `HTX_IDX_FIFO, v);
      end
      if (!c1[0])
      begin
         b.push_back(~s[7:0]);
         b.push_back(~s[15:8]);
      end
      repeat (cp)
         fq = {fq, b};
      if (fin == 8'h04)
         apb(1'b1, `HTX_IDX_CTL1, c1);
   endtask

   task automatic drain(input int left, input int idle);
      int n = 0;
      while (fq.size() > left && n++ < 30000)
         @(posedge clk_sys);
      if (fq.size() > left)
      begin
         err_count++;
         conclude();
      end
      repeat (idle)
         @(posedge clk_sys);
   endtask

   // ==========
   // Main sequence
   initial
   begin
      void'($urandom(27));
      repeat (3)
         @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, `HTX_IDX_CTL1, 8'h00);
      apb(1'b0, `HTX_IDX_SUPP, 8'h00);
      apb(1'b0, `HTX_IDX_CTL2, 8'h00);
      apb(1'b0, 10'h115, 8'h00, 1'b1);
      r = 8'($urandom) & 8'hee;
      sp <= r;
      apb(1'b1, `HTX_IDX_SUPP, r);
      apb(1'b0, `HTX_IDX_SUPP, r);
      en <= 1'b1;
      apb(1'b1, `HTX_IDX_CTL2, 8'h20);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, `HTX_IDX_CTL1, {4'h1, i[0], 3'h0});
         f0 = flag_cnt;
         repeat (300)
            @(posedge clk_sys);
         chk("fill", flag_cnt - f0 > 10, !i[0]);
      end
      $display("TB: fill test done");
      for (int i = 0; i < 4; i++)
      begin
         c = {i[0], 2'h0, 1'b1, 1'b1, 2'h0, i[1]};
         apb(1'b1, `HTX_IDX_CTL1, c);
         f0 = flag_cnt;
         send(3, c, 8'h04, 1);
         send(2, c, 8'h04, 1);
         drain(0, 300);
         chk("flags", flag_cnt - f0, 3 + 2 * i[0]);
      end
      $display("TB: frame test done");
      apb(1'b1, `HTX_IDX_CTL1, 8'h10);
      f0 = abort_cnt;
      repeat (3)
         apb(1'b1, `HTX_IDX_FIFO, 8'h55);
      apb(1'b1, `HTX_IDX_CTL2, 8'ha0);
      apb(1'b1, `HTX_IDX_CTL2, 8'ha0);
      repeat (300)
         @(posedge clk_sys);
      chk("abort", abort_cnt - f0, 1);
      apb(1'b1, `HTX_IDX_CTL2, 8'h20);
      apb(1'b1, `HTX_IDX_CTL2, 8'ha0);
      repeat (300)
         @(posedge clk_sys);
      chk("abort", abort_cnt - f0, 2);
      $display("TB: abort test done");
      // Channel changes only count at a controller reset
      use_ch <= 1'b1;
      apb(1'b1, `HTX_IDX_CTL2, 8'h22);
      f0 = abort_cnt;
      apb(1'b1, `HTX_IDX_CTL1, 8'h20);
      lch <= 5'h02;
      apb(1'b0, `HTX_IDX_CTL1, 8'h20);
      repeat (2500)
         @(posedge clk_sys);
      apb(1'b0, `HTX_IDX_CTL1, 8'h00);
      chk("reset_abort", abort_cnt - f0, 1);
      apb(1'b1, `HTX_IDX_CTL2, 8'h23);
      send(2, 8'h00, 8'h04, 1);
      drain(0, 300);
      apb(1'b1, `HTX_IDX_CTL2, 8'h03);
      en <= 1'b0;
      repeat (300)
         @(posedge clk_sys);
      $display("TB: channel test done");
      r = 8'($urandom) & 8'h3f;
      apb(1'b1, `HTX_IDX_BOC, r);
      apb(1'b1, `HTX_IDX_CTL2, 8'h40);
      @(negedge clk_sys);
      chk("boc", {boc_send, boc_code}, {1'b1, r[5:0]});
      @(posedge clk_sys);
      t1_mode <= 1'b0;
      repeat (2)
         @(negedge clk_sys);
      chk("boc_t1", boc_send, 1'b0);
      @(posedge clk_sys);
      use_ch <= 1'b0;
      en <= 1'b1;
      apb(1'b1, `HTX_IDX_CTL1, 8'h10);
      apb(1'b1, `HTX_IDX_CTL2, 8'h20);
      send(3, 8'h10, 8'h40, 3);
      drain(5, 0);
      apb(1'b1, `HTX_IDX_CTL1, 8'h10);
      drain(0, 600);
      apb(1'b0, `HTX_IDX_STAT, 8'h01);
      $display("TB: loop test done");
      conclude();
   end
endmodule
